// ==== common/asi_pkg.sv ====
// constants and types shared by the a16/d16 slave interface
// assumes one clock domain and an active-low asynchronous reset
// Function
// - accept only address modifier 29 or 2d, a15/a14 high, long-word line inactive
// - select an on-board register only with a5/a4 low, a3..a1 choosing it
// - control register is 8 bits: soft reset, fail block, six user outputs
// - control select plus one-cycle write strobe loads low data byte into control
// - transfer machine leaves idle on card match with both data strobes active
// - first active state enables data buffers and latches register address bits
// - read puts selected register on data, next state drives transfer acknowledge
// - write inserts one strobe state loading control before acknowledge
// - status, id and type registers never drive data during a write
// - acknowledge and latch held until strobes drop, then release, then idle
// - acknowledge inhibit holds machine in first active state without acknowledging
// - request and acknowledge use one selectable level out of eight
// - user interrupt input with quiet acknowledge lines drives the request line
// - handler puts level on a3..a1 and asserts iack; normal decoding suppressed
// - not requesting or other level: pass daisy chain, gated by address strobe
// - matching acknowledge: local ack, drop request, read returns logical address
// - fail line driven from failure input only while fail block bit is low
// - hardware reset clears control register and asserts soft reset line
// - writing one to control bit 0 asserts soft reset line
package asi_pkg;
  localparam logic [3:0] CTL_OFFSET = 4'h4;
  localparam logic [5:0] AM_SHORT_A = 6'h29;
  localparam logic [5:0] AM_SHORT_B = 6'h2d;
  localparam logic [2:0] SEL_ID = 3'h0;
  localparam logic [2:0] SEL_DEVTYPE = 3'h1;
  localparam int CTL_WIDTH = 8;
  localparam int CTL_RESET_BIT = 0;
  localparam int CTL_FAIL_BLOCK_BIT = 1;
  localparam int CTL_USER_LSB = 2;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] PULLUP_BYTE = 8'hff;
  localparam logic [15:0] PULLUP_WORD = 16'hffff;

  typedef enum logic [4:0] {
    XF_IDLE = 5'h01,
    XF_EN = 5'h02,
    XF_WR = 5'h04,
    XF_ACK = 5'h08,
    XF_REL = 5'h10
  } asi_xfer_e;

  typedef enum logic [2:0] {
    IQ_IDLE = 3'h1,
    IQ_REQ = 3'h2,
    IQ_ACKD = 3'h4
  } asi_irq_e;
endpackage

// ==== common/asi_irq_if.sv ====
// signals between the transfer core and the interrupt requester
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface asi_irq_if;
  logic int_request;
  logic iack_n;
  logic iackin_n;
  logic as_n;
  logic ds0_n;
  logic [2:0] addr_lvl;
  logic [2:0] level;
  logic int_request_drive;
  logic local_int_ack_n;
  logic iackout_n;
  logic ack_level_match;
  modport irq_side (
    input int_request, iack_n, iackin_n, as_n, ds0_n, addr_lvl, level,
    output int_request_drive, local_int_ack_n, iackout_n, ack_level_match
  );
  modport core_side (
    output int_request, iack_n, iackin_n, as_n, ds0_n, addr_lvl, level,
    input int_request_drive, local_int_ack_n, iackout_n, ack_level_match
  );
endinterface
`default_nettype wire

// ==== design/asi_ctl_reg.sv ====
// control register: loads the low data byte on a one-cycle strobe
// assumes load is a single-cycle pulse from the transfer machine
`timescale 1ns/1ps
`default_nettype none
module asi_ctl_reg #(
  parameter int WIDTH = asi_pkg::CTL_WIDTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // load side
  input wire logic load,
  input wire logic [WIDTH-1:0] data,
  // register outputs
  output logic [WIDTH-1:0] ctl
);
  typedef struct packed {
    logic [WIDTH-1:0] ctl;
  } asi_ctl_s;

  asi_ctl_s r;
  asi_ctl_s next_r;

  always_comb begin
    next_r = r;
    if (load) begin
      next_r.ctl = data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{ctl: WIDTH'(asi_pkg::CTL_RESET)};
    end else begin
      r <= next_r;
    end
  end

  assign ctl = r.ctl;

  property p_ctl_hold;
    @(posedge clk) disable iff (!resetn) !load |=> ctl == $past(ctl);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control changed without load");
endmodule
`default_nettype wire

// ==== design/asi_irq_fsm.sv ====
// daisy-chained interrupt requester
// assumes the handler holds the acknowledged level on a3..a1 while iack is low
`timescale 1ns/1ps
`default_nettype none
module asi_irq_fsm (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link to the core
  asi_irq_if.irq_side irq
);
  typedef struct packed {
    asi_pkg::asi_irq_e st;
  } asi_irq_s;

  asi_irq_s r;
  asi_irq_s next_r;
  logic match;

  assign match = (irq.addr_lvl == irq.level);
  assign irq.ack_level_match = match;

  always_comb begin
    next_r = r;
    case (r.st)
      asi_pkg::IQ_IDLE: begin
        // waiting for a quiet bus avoids joining an acknowledge already in flight
        if (irq.int_request && irq.iack_n && irq.as_n) begin
          next_r.st = asi_pkg::IQ_REQ;
        end
      end
      asi_pkg::IQ_REQ: begin
        if (!irq.iackin_n && !irq.iack_n && !irq.as_n && match) begin
          next_r.st = asi_pkg::IQ_ACKD;
        end else if (!irq.int_request && irq.as_n) begin
          next_r.st = asi_pkg::IQ_IDLE;
        end
      end
      asi_pkg::IQ_ACKD: begin
        // hold ownership until the vector read has fully ended on the bus
        if (irq.as_n && irq.ds0_n) begin
          next_r.st = asi_pkg::IQ_IDLE;
        end
      end
      default: next_r.st = asi_pkg::IQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: asi_pkg::IQ_IDLE};
    end else begin
      r <= next_r;
    end
  end

  assign irq.int_request_drive = (r.st == asi_pkg::IQ_REQ);
  assign irq.local_int_ack_n = (r.st != asi_pkg::IQ_ACKD);
  // pass on unless we own this acknowledge; as_n gating releases it at once
  assign irq.iackout_n = irq.iackin_n || irq.as_n ||
    (r.st == asi_pkg::IQ_ACKD) || ((r.st == asi_pkg::IQ_REQ) && match);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ack_drops_req;
    irq.int_request_drive && !irq.iackin_n && !irq.iack_n && !irq.as_n && match
      |=> !irq.local_int_ack_n && !irq.int_request_drive;
  endproperty
  a_ack_drops_req: assert property (p_ack_drops_req) else $error("own ack not taken");

  property p_pass_chain;
    !irq.iackin_n && !irq.as_n && !irq.int_request_drive && irq.local_int_ack_n
      |-> !irq.iackout_n;
  endproperty
  a_pass_chain: assert property (p_pass_chain) else $error("daisy chain not passed");

  property p_no_pass_owned;
    !irq.local_int_ack_n |-> irq.iackout_n;
  endproperty
  a_no_pass_owned: assert property (p_no_pass_owned) else $error("owned ack passed on");

  c_irq_ack: cover property (irq.int_request_drive ##[1:50] !irq.local_int_ack_n);
endmodule
`default_nettype wire

// ==== design/asi_top.sv ====
// backplane slave interface: decode, transfer machine, data path, control
// assumes backplane inputs are already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module asi_top (
  // clock and hardware reset
  input wire logic clk,
  input wire logic resetn,
  // backplane address and strobes
  input wire logic [15:1] addr,
  input wire logic [5:0] am,
  input wire logic lword_n,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic write_n,
  input wire logic iack_n,
  input wire logic iackin_n,
  output logic iackout_n,
  // backplane data, two-way
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // open-collector backplane lines, enable high pulls low
  output logic dtack_oe,
  output logic irq_oe,
  output logic sysfail_oe,
  // board straps and user inputs
  input wire logic [7:0] logical_address_switch,
  input wire logic [2:0] irq_level,
  input wire logic [15:0] id_value,
  input wire logic [15:0] device_type_value,
  input wire logic [7:0] status_value,
  input wire logic int_request,
  input wire logic ack_hold_inhibit,
  input wire logic fail_in,
  // user-side outputs
  output logic card_match_n,
  output logic bus_buffer_enable_n,
  output logic [5:1] latched_addr,
  output logic [7:0] reg_enable_n,
  output logic local_int_ack_n,
  output logic int_request_drive,
  output logic soft_reset_line_n,
  output logic fail_report_block,
  output logic [5:0] ctl_user_bits
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    asi_pkg::asi_xfer_e st;
    logic [5:1] laddr;
    logic rd;
    logic iack_cyc;
    logic [15:0] dout;
  } asi_top_s;

  asi_top_s r;
  asi_top_s next_r;
  asi_irq_if irq_bus ();
  logic [7:0] ctl;
  logic am_ok;
  logic card_match;
  logic ds_act;
  logic ds_idle;
  logic start;
  logic sel_ok;
  logic ctl_load;
  logic ctl_reset_bit;
  logic ctl_fail_block_bit;

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  assign am_ok = (am == asi_pkg::AM_SHORT_A) || (am == asi_pkg::AM_SHORT_B);
  // iack low suppresses the card match so a vector fetch never hits a register
  assign card_match = am_ok && (addr[15:14] == 2'b11) && lword_n && iack_n &&
    (addr[13:6] == logical_address_switch);
  assign card_match_n = !card_match;
  assign ds_act = !ds0_n && !ds1_n;
  assign ds_idle = ds0_n && ds1_n;
  assign start = ds_act && (card_match || !local_int_ack_n);
  assign sel_ok = !r.iack_cyc && (r.laddr[5:4] == 2'b00);

  //////////////////////////////////////////////////////////////////////////////
  // transfer machine
  always_comb begin
    next_r = r;
    case (r.st)
      asi_pkg::XF_IDLE: begin
        next_r.laddr = addr[5:1];
        if (start) begin
          next_r.st = asi_pkg::XF_EN;
          next_r.rd = write_n || !local_int_ack_n;
          next_r.iack_cyc = !local_int_ack_n;
        end
      end
      asi_pkg::XF_EN: begin
        // read data is registered here so the word is steady from the edge that raises the acknowledge
        if (r.iack_cyc) begin
          next_r.dout = {asi_pkg::PULLUP_BYTE, logical_address_switch};
        end else if (!sel_ok) begin
          next_r.dout = asi_pkg::PULLUP_WORD;
        end else if (r.laddr[3:1] == asi_pkg::SEL_ID) begin
          next_r.dout = id_value;
        end else if (r.laddr[3:1] == asi_pkg::SEL_DEVTYPE) begin
          next_r.dout = device_type_value;
        end else if (r.laddr[3:1] == asi_pkg::CTL_OFFSET[3:1]) begin
          next_r.dout = {asi_pkg::PULLUP_BYTE, status_value};
        end else begin
          next_r.dout = asi_pkg::PULLUP_WORD;
        end
        if (ack_hold_inhibit) begin
          next_r.st = asi_pkg::XF_EN;
        end else if (!r.rd) begin
          next_r.st = asi_pkg::XF_WR;
        end else begin
          next_r.st = asi_pkg::XF_ACK;
        end
      end
      asi_pkg::XF_WR: begin
        next_r.st = asi_pkg::XF_ACK;
      end
      asi_pkg::XF_ACK: begin
        if (ds_idle) begin
          next_r.st = asi_pkg::XF_REL;
        end
      end
      asi_pkg::XF_REL: begin
        next_r.st = asi_pkg::XF_IDLE;
        next_r.laddr = addr[5:1];
        next_r.rd = 1'b0;
        next_r.iack_cyc = 1'b0;
      end
      default: next_r.st = asi_pkg::XF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: asi_pkg::XF_IDLE, laddr: 5'h00, rd: 1'b0, iack_cyc: 1'b0,
             dout: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs of the transfer machine
  assign bus_buffer_enable_n = !(r.st == asi_pkg::XF_EN || r.st == asi_pkg::XF_WR ||
    r.st == asi_pkg::XF_ACK);
  assign latched_addr = r.laddr;
  // drive only on reads, so a write never meets our registers on the bus
  assign data_oe = r.rd && !bus_buffer_enable_n;
  assign data_out = r.dout;
  assign dtack_oe = (r.st == asi_pkg::XF_ACK) || (r.st == asi_pkg::XF_REL);

  generate
    for (genvar i = 0; i < 8; i++) begin : g_enable
      assign reg_enable_n[i] = !(sel_ok && !bus_buffer_enable_n &&
        (r.laddr[3:1] == 3'(i)));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // control register
  assign ctl_load = (r.st == asi_pkg::XF_WR) && sel_ok &&
    (r.laddr[3:1] == asi_pkg::CTL_OFFSET[3:1]);

  asi_ctl_reg #(
    .WIDTH(asi_pkg::CTL_WIDTH)
  ) u_ctl (
    .clk(clk),
    .resetn(resetn),
    .load(ctl_load),
    .data(data_in[7:0]),
    .ctl(ctl)
  );

  assign ctl_reset_bit = ctl[asi_pkg::CTL_RESET_BIT];
  assign ctl_fail_block_bit = ctl[asi_pkg::CTL_FAIL_BLOCK_BIT];
  assign soft_reset_line_n = resetn && !ctl_reset_bit;
  assign fail_report_block = ctl_fail_block_bit;
  assign ctl_user_bits = ctl[7:asi_pkg::CTL_USER_LSB];
  assign sysfail_oe = fail_in && !ctl_fail_block_bit;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt requester
  assign irq_bus.int_request = int_request;
  assign irq_bus.iack_n = iack_n;
  assign irq_bus.iackin_n = iackin_n;
  assign irq_bus.as_n = as_n;
  assign irq_bus.ds0_n = ds0_n;
  assign irq_bus.addr_lvl = addr[3:1];
  assign irq_bus.level = irq_level;

  asi_irq_fsm u_irq (
    .clk(clk),
    .resetn(resetn),
    .irq(irq_bus)
  );

  assign int_request_drive = irq_bus.int_request_drive;
  assign irq_oe = irq_bus.int_request_drive;
  assign local_int_ack_n = irq_bus.local_int_ack_n;
  assign iackout_n = irq_bus.iackout_n;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_match_cond;
    !card_match_n |-> am_ok && addr[15] && addr[14] && lword_n && iack_n;
  endproperty
  a_match_cond: assert property (p_match_cond) else $error("bad card match");

  property p_start;
    r.st == asi_pkg::XF_IDLE && start |=> r.st == asi_pkg::XF_EN && !bus_buffer_enable_n;
  endproperty
  a_start: assert property (p_start) else $error("transfer did not start");

  property p_latch_held;
    r.st == asi_pkg::XF_EN ##1 r.st != asi_pkg::XF_REL && r.st != asi_pkg::XF_IDLE
      |-> $stable(latched_addr);
  endproperty
  a_latch_held: assert property (p_latch_held) else $error("address latch moved");

  property p_read_ack;
    r.st == asi_pkg::XF_EN && !ack_hold_inhibit && r.rd |=> dtack_oe && data_oe;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read not acknowledged");

  property p_write_seq;
    r.st == asi_pkg::XF_EN && !ack_hold_inhibit && !r.rd
      |=> !dtack_oe && r.st == asi_pkg::XF_WR ##1 dtack_oe;
  endproperty
  a_write_seq: assert property (p_write_seq) else $error("write strobe state missing");

  // watches the backplane direction line, not the latched flag that feeds data_oe
  property p_write_quiet;
    !write_n |-> !data_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drove data on write");

  property p_hold_ack;
    r.st == asi_pkg::XF_ACK && !ds_idle |=> dtack_oe && !bus_buffer_enable_n;
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("ack dropped early");

  property p_release;
    r.st == asi_pkg::XF_ACK && ds_idle |=> dtack_oe && bus_buffer_enable_n ##1
      !dtack_oe && r.st == asi_pkg::XF_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("release order wrong");

  property p_inhibit;
    r.st == asi_pkg::XF_EN && ack_hold_inhibit |=> r.st == asi_pkg::XF_EN && !dtack_oe;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("acked under inhibit");

  property p_ctl_load;
    ctl_load |=> ctl == $past(data_in[7:0]);
  endproperty
  a_ctl_load: assert property (p_ctl_load) else $error("control not loaded");

  property p_sysfail;
    sysfail_oe |-> fail_in && !ctl[1];
  endproperty
  a_sysfail: assert property (p_sysfail) else $error("fail driven while blocked");

  property p_soft_reset;
    ctl_load && data_in[0] |=> !soft_reset_line_n;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not driven");

  property p_iack_data;
    r.st == asi_pkg::XF_EN && r.iack_cyc |=> data_out[7:0] == $past(logical_address_switch);
  endproperty
  a_iack_data: assert property (p_iack_data) else $error("wrong logical address");

  c_read: cover property (r.st == asi_pkg::XF_EN && r.rd ##1 dtack_oe ##[1:20] !dtack_oe);
  c_write: cover property (ctl_load ##[1:20] r.st == asi_pkg::XF_IDLE);
  c_iack: cover property (r.iack_cyc && dtack_oe);
  c_inhibit: cover property (r.st == asi_pkg::XF_EN && ack_hold_inhibit [*3]);
endmodule
`default_nettype wire

// ==== verif/asi_bp_model.sv ====
// backplane system controller and interrupt handler model for the slave interface
// assumes one caller at a time; every change lands 1 ns after clk rises
`timescale 1ns/1ps
`default_nettype none
module asi_bp_model (
  // clock
  input wire logic clk,
  // device answers
  input wire logic dtack_oe,
  input wire logic data_oe,
  input wire logic [15:0] data_out,
  input wire logic [7:0] reg_enable_n,
  input wire logic irq_oe,
  input wire logic local_int_ack_n,
  input wire logic iackout_n,
  // backplane drive
  output logic [15:1] addr,
  output logic [5:0] am,
  output logic lword_n,
  output logic as_n,
  output logic ds0_n,
  output logic ds1_n,
  output logic write_n,
  output logic iack_n,
  output logic iackin_n,
  output logic [15:0] data_in
);
  logic oe_seen, dt_drop, rel_dt, idle_dt;
  logic [7:0] en_seen;
  logic [1:0] ack_seen;
  initial begin
    {addr, am} = '0;
    {lword_n, as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n} = 7'h7f;
    data_in = 16'h0000;
  end
  //////////////////////////////////////////////////////////////////////////
  // released strobes go high and address and data show their inverse, so stale data never matches
  task automatic release_bus();
    #1;
    {as_n, ds0_n, ds1_n, iack_n, iackin_n} = 5'h1f;
    addr = ~addr;
    data_in = ~data_in;
  endtask
  task automatic xfer(input logic wr, ia, input logic [15:1] a, input logic [5:0] m,
                      input logic lw, input logic [15:0] wd, input int hold,
                      output logic [15:0] rd, output int lat);
    lat = 0;
    rd = 16'h0000;
    @(posedge clk);
    #1;
    addr = a;
    am = m;
    lword_n = lw;
    write_n = ~wr;
    iack_n = ~ia;
    iackin_n = ~ia;
    as_n = 1'b0;
    if (wr) data_in = wd;
    @(posedge clk);
    #1;
    ds0_n = 1'b0;
    ds1_n = 1'b0;
    oe_seen = 1'b0;
    dt_drop = 1'b0;
    for (int n = 1; n <= 20 && lat == 0; n++) begin
      @(posedge clk);
      oe_seen = oe_seen | data_oe;
      if (dtack_oe === 1'b1) begin
        lat = n;
        rd = data_out;
        en_seen = reg_enable_n;
        ack_seen = {irq_oe, local_int_ack_n};
      end
    end
    // slow master: strobes stay low after the acknowledge for hold cycles
    repeat (hold) begin
      @(posedge clk);
      if (dtack_oe !== 1'b1) dt_drop = 1'b1;
    end
    release_bus();
    @(posedge clk);
    @(posedge clk);
    rel_dt = dtack_oe;
    @(posedge clk);
    idle_dt = dtack_oe;
    #1;
  endtask
  task automatic probe(input logic [2:0] lvl, output logic out_n);
    @(posedge clk);
    #1;
    addr = {12'h000, lvl};
    iack_n = 1'b0;
    iackin_n = 1'b0;
    as_n = 1'b0;
    repeat (2) @(posedge clk);
    out_n = iackout_n;
    release_bus();
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the a16/d16 slave interface top
// assumes the model drives the backplane and this bench drives the board side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] logical_address_switch = 8'h5c;
  logic [2:0] irq_level = 3'h3;
  // strap values are arbitrary
  logic [15:0] id_value = 16'h4e21;
  logic [15:0] device_type_value = 16'hff3a;
  logic [7:0] status_value = 8'hc5;
  logic int_request = 1'b0, ack_hold_inhibit = 1'b0, fail_in = 1'b0;
  logic [15:1] addr, a;
  logic [5:0] am, m, ctl_user_bits;
  logic lword_n, as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n, iackout_n, lw, o;
  logic data_oe, dtack_oe, irq_oe, sysfail_oe, card_match_n, bus_buffer_enable_n;
  logic local_int_ack_n, int_request_drive, soft_reset_line_n, fail_report_block;
  logic [15:0] data_in, data_out, rd, ex;
  logic [5:1] latched_addr;
  logic [7:0] reg_enable_n;
  int error_cnt = 0, n_compared = 0, cyc = 0, lat;
  asi_top asi_top_inst (.clk, .resetn, .addr, .am, .lword_n, .as_n, .ds0_n, .ds1_n, .write_n,
    .iack_n, .iackin_n, .iackout_n, .data_in, .data_out, .data_oe, .dtack_oe, .irq_oe,
    .sysfail_oe, .logical_address_switch, .irq_level, .id_value, .device_type_value,
    .status_value, .int_request, .ack_hold_inhibit, .fail_in, .card_match_n,
    .bus_buffer_enable_n, .latched_addr, .reg_enable_n, .local_int_ack_n, .int_request_drive,
    .soft_reset_line_n, .fail_report_block, .ctl_user_bits);
  asi_bp_model asi_bp_model_inst (.clk, .dtack_oe, .data_oe, .data_out, .reg_enable_n, .irq_oe,
    .local_int_ack_n, .iackout_n, .addr, .am, .lword_n, .as_n, .ds0_n, .ds1_n, .write_n,
    .iack_n, .iackin_n, .data_in);
  always #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("[TEST] %s ended, mismatches so far %0d", nm, error_cnt);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the whole run needs well under 1000 cycles; a hang stops at the ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  function automatic logic [15:1] ra(input logic [2:0] s);
    return {2'b11, logical_address_switch, 2'b00, s};
  endfunction
  task automatic rdr(input logic [15:1] ad, input logic [5:0] md, input logic l, input int h);
    asi_bp_model_inst.xfer(1'b0, 1'b0, ad, md, l, 16'h0000, h, rd, lat);
  endtask
  task automatic wrr(input logic [2:0] s, input logic [7:0] b);
    asi_bp_model_inst.xfer(1'b1, 1'b0, ra(s), asi_pkg::AM_SHORT_B, 1'b1, {8'h96, b}, 0, rd, lat);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk("soft reset held", 0, soft_reset_line_n);
    chk("idle in reset", 0, {dtack_oe, irq_oe});
    chk("control in reset", 0, {fail_report_block, ctl_user_bits});
    resetn = 1'b1;
    @(posedge clk);
    #1;
    chk("soft reset after", 1, soft_reset_line_n);
    done("reset");
    for (int s = 0; s < 8; s++) begin
      rdr(ra(s[2:0]), s[0] ? asi_pkg::AM_SHORT_B : asi_pkg::AM_SHORT_A, 1'b1, s);
      ex = s == 0 ? id_value : s == 1 ? device_type_value : 16'hffff;
      if (s == 2) ex = {8'hff, status_value};
      chk("read data", ex, rd);
      chk("reg select", ~(16'h0001 << s), {8'hff, asi_bp_model_inst.en_seen});
      chk_n("read latency", 3, lat);
      chk("data drive in read", 1, asi_bp_model_inst.oe_seen);
      chk("ack under hold", 0, asi_bp_model_inst.dt_drop);
      chk("release order", 2, {asi_bp_model_inst.rel_dt, asi_bp_model_inst.idle_dt});
    end
    for (int k = 1; k < 4; k++) begin
      rdr({2'b11, logical_address_switch, k[1:0], 3'h2}, asi_pkg::AM_SHORT_A, 1'b1, 0);
      chk("unselected data", 16'hffff, rd);
      chk("unselected enable", 8'hff, asi_bp_model_inst.en_seen);
    end
    for (int k = 0; k < 5; k++) begin
      a = ra(3'h0);
      m = asi_pkg::AM_SHORT_A;
      lw = 1'b1;
      case (k)
        0: m = 6'h39;
        1: lw = 1'b0;
        2: a[15] = 1'b0;
        3: a[14] = 1'b0;
        default: a[13:6] = ~logical_address_switch;
      endcase
      rdr(a, m, lw, 0);
      chk_n("refused", 0, lat);
    end
    done("reads");
    fail_in = 1'b1;
    wrr(3'h2, 8'ha6);
    chk_n("write latency", 4, lat);
    chk("data drive in write", 0, asi_bp_model_inst.oe_seen);
    chk("user bits", 6'h29, ctl_user_bits);
    chk("fail block", 1, fail_report_block);
    chk("fail blocked", 0, sysfail_oe);
    wrr(3'h0, 8'h55);
    chk("other select", 6'h29, ctl_user_bits);
    wrr(3'h2, 8'h01);
    chk("soft reset bit", 0, soft_reset_line_n);
    chk("fail unblocked", 1, sysfail_oe);
    wrr(3'h2, 8'hfc);
    chk("soft reset clear", 1, soft_reset_line_n);
    chk("user bits high", 6'h3f, ctl_user_bits);
    fail_in = 1'b0;
    done("control");
    ack_hold_inhibit = 1'b1;
    fork
      rdr(ra(3'h2), asi_pkg::AM_SHORT_A, 1'b1, 0);
      begin
        repeat (8) @(posedge clk);
        #1;
        chk("buffers held", 0, bus_buffer_enable_n);
        chk("no ack held", 0, dtack_oe);
        chk("address latched", 5'h02, latched_addr);
        chk("card match", 0, card_match_n);
        ack_hold_inhibit = 1'b0;
      end
    join
    chk("inhibit delay", 1, lat > 6);
    done("inhibit");
    int_request = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("request", 3, {irq_oe, int_request_drive});
    asi_bp_model_inst.probe(3'h5, o);
    chk("daisy pass", 0, o);
    chk("request kept", 1, irq_oe);
    chk("daisy released", 1, iackout_n);
    asi_bp_model_inst.xfer(1'b0, 1'b1, {12'h000, irq_level}, 6'h29, 1'b1, 0, 0, rd, lat);
    chk("vector", {8'hff, logical_address_switch}, rd);
    chk("own ack", 0, asi_bp_model_inst.ack_seen);
    chk("iack decode", 8'hff, asi_bp_model_inst.en_seen);
    int_request = 1'b0;
    asi_bp_model_inst.probe(irq_level, o);
    chk("idle pass", 0, o);
    done("interrupt");
    int_request = 1'b1;
    fork
      rdr(ra(3'h1), asi_pkg::AM_SHORT_A, 1'b1, 6);
      begin
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b0;
        #1;
        chk("reset mid", 0, {dtack_oe, irq_oe, soft_reset_line_n});
      end
    join
    chk("read before reset", device_type_value, rd);
    int_request = 1'b0;
    resetn = 1'b1;
    @(posedge clk);
    #1;
    chk("control cleared", 0, {fail_report_block, ctl_user_bits});
    done("reset mid run");
    summarize();
  end
endmodule
`default_nettype wire
